/* core/pmc_pkg.sv */
package pmc_pkg;
  // How it works
  // - Mode 00 normal, 01 holdover, 10 free-run
  // - Pin modes captured on frame pulse rise
  // - Filter low 1.1 Hz, high 0.1 Hz
  // - Realign slope limited per filter choice
  // - Reference pin choice sampled on frame pulse
  // - Realign command aligns outputs to reference
  // - Falling edge of realign control triggers
  // - Lock high while locked to selected
  // - Holdover high on acquisition holdover in normal mode, or in mode holdover
  // - Pin select low uses register bits
  // - Status outputs stay active in software
  // - Recovery disable and manual recovery bits
  // - Report frequency limit and holdover flags
  // - Control register bit layout at 00
  // - Status register lock, holdover, limit
  // - Eleven bit coarse offset over 06/07
  // - Calibration word at 40-43, MSB first
  // - Acquisition status: rate, holdover, limit
  // - Clock gate bits disable outputs
  // - Core limit flag at tracking edge
  localparam logic [6:0] ADDR_CTRL     = 7'h00;
  localparam logic [6:0] ADDR_STAT     = 7'h01;
  localparam logic [6:0] ADDR_RATE     = 7'h04;
  localparam logic [6:0] ADDR_OFS_HI   = 7'h06;
  localparam logic [6:0] ADDR_OFS_LO   = 7'h07;
  localparam logic [6:0] ADDR_IDENT    = 7'h0f;
  localparam logic [6:0] ADDR_T1ADJ    = 7'h11;
  localparam logic [6:0] ADDR_GATE_A   = 7'h13;
  localparam logic [6:0] ADDR_GATE_B   = 7'h14;
  localparam logic [6:0] ADDR_RECOV    = 7'h19;
  localparam logic [6:0] ADDR_FINE     = 7'h1a;
  localparam logic [6:0] ADDR_PRI_ST   = 7'h20;
  localparam logic [6:0] ADDR_SEC_ST   = 7'h28;
  localparam logic [6:0] ADDR_CAL3     = 7'h40;
  localparam logic [6:0] ADDR_CAL2     = 7'h41;
  localparam logic [6:0] ADDR_CAL1     = 7'h42;
  localparam logic [6:0] ADDR_CAL0     = 7'h43;
  // Writable bit masks
  localparam logic [7:0] MASK_CTRL     = 8'h9d;
  localparam logic [7:0] MASK_RATE     = 8'hc0;
  localparam logic [7:0] MASK_OFS_HI   = 8'h0f;
  localparam logic [7:0] MASK_T1ADJ    = 8'h38;
  localparam logic [7:0] MASK_GATE_A   = 8'h3e;
  localparam logic [7:0] MASK_GATE_B   = 8'h1f;
  localparam logic [7:0] MASK_RECOV    = 8'h03;
  // Control field positions
  localparam int         CTRL_REFERENCE_CHOICE   = 7;
  localparam int         CTRL_MODE_HI  = 4;
  localparam int         CTRL_MODE_LO  = 3;
  localparam int         CTRL_FILTER   = 2;
  localparam int         CTRL_ALIGN    = 0;
  localparam int         REC_MANUAL    = 1;
  localparam int         REC_DISABLE   = 0;
  localparam logic [7:0] RST_CTRL      = 8'h10;
  // Modes
  localparam logic [1:0] MODE_NORMAL   = 2'h0;
  localparam logic [1:0] MODE_HOLD     = 2'h1;
  localparam logic [1:0] MODE_FREE     = 2'h2;
  // Filter corners in centihertz and phase slopes
  localparam int         CORNER_WIDE_CHZ  = 110;
  localparam int         CORNER_NARROW_CHZ = 10;
  localparam int         SLOPE_WIDE_NS    = 41;
  localparam int         SLOPE_WIDE_US    = 1326;
  localparam int         SLOPE_NARROW_NS  = 885;
  localparam int         SLOPE_NARROW_US  = 1000000;
  localparam int         CLK_MHZ          = 100;
  // Cycles per 1 ns phase step, rounded up so slope never exceeds limit
  localparam int         STEP_WIDE_CYC   =
    (SLOPE_WIDE_US * CLK_MHZ + SLOPE_WIDE_NS - 1) / SLOPE_WIDE_NS;
  localparam int         STEP_NARROW_CYC =
    (SLOPE_NARROW_US * CLK_MHZ + SLOPE_NARROW_NS - 1) / SLOPE_NARROW_NS;
  localparam int         TRACK_PPM       = 104;
endpackage

/* core/pmc_bus_if.sv */
`timescale 1ns/10ps
interface pmc_bus_if;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  modport host (output addr, output wdata, output wr, output rd);
  modport regs (input addr, input wdata, input wr, input rd);
endinterface

/* core/pmc_slew.sv */
`timescale 1ns/10ps
// Rate limiter: emits one 1 ns phase step per interval while realign runs
module pmc_slew #(
  parameter int STEP_WIDE   = pmc_pkg::STEP_WIDE_CYC,
  parameter int STEP_NARROW = pmc_pkg::STEP_NARROW_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_active,
  input  wire logic i_narrow,
  output logic      o_step
);
  logic [23:0] count;
  wire  [23:0] limit = i_narrow ? 24'(STEP_NARROW - 1) : 24'(STEP_WIDE - 1);
  wire         wrap  = (count >= limit);

  // Step spacing follows the selected filter
  always_ff @(posedge i_clk) begin
    if (i_reset || !i_active) begin
      count  <= 24'h00_0000;
      o_step <= 1'b0;
    end else begin
      count  <= wrap ? 24'h00_0000 : count + 24'h00_0001;
      o_step <= wrap;
    end
  end

  step_gap_a: assert property (@(posedge i_clk) disable iff (i_reset)
    o_step |=> !o_step) else $error("Phase steps back to back");
endmodule

/* core/pmc_top.sv */
`timescale 1ns/10ps
module pmc_top #(
  parameter logic [7:0] IDENT_CODE = 8'h5a, // Arbitrary identity value
  parameter int         PHASE_NS  = 16'd5000
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_pin_control_select,
  input  wire logic        i_mode_sel_hi,
  input  wire logic        i_mode_sel_lo,
  input  wire logic        i_filter_select,
  input  wire logic        i_reference_choice,
  input  wire logic        i_phase_realign,
  input  wire logic        i_frame_pulse_8khz,
  input  wire logic        i_core_locked,
  input  wire logic        i_core_freq_limit_flag,
  input  wire logic        i_primary_acq_holdover_flag,
  input  wire logic        i_primary_freq_limit_flag,
  input  wire logic [1:0]  i_primary_rate,
  input  wire logic        i_secondary_acq_holdover_flag,
  input  wire logic        i_secondary_freq_limit_flag,
  input  wire logic [1:0]  i_secondary_rate,
  input  wire logic [6:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [7:0]       o_rdata,
  output logic             o_lock,
  output logic             o_holdover,
  output logic [1:0]       o_mode,
  output logic             o_filter_narrow,
  output logic             o_reference_choice,
  output logic             o_realign_busy,
  output logic             o_phase_step,
  output logic             o_auto_recovery_disable,
  output logic             o_manual_recovery_request,
  output logic [10:0]      o_coarse_phase_offset_value,
  output logic             o_phase_offset_enable,
  output logic [7:0]       o_fine_phase_offset_value,
  output logic [2:0]       o_t1_phase_offset_value,
  output logic [1:0]       o_rate_select,
  output logic [13:0]      o_clock_disable,
  output logic [31:0]      o_oscillator_calibration_value
);
  pmc_bus_if bus ();
  assign bus.addr  = i_addr;
  assign bus.wdata = i_wdata;
  assign bus.wr    = i_wr;
  assign bus.rd    = i_rd;

  // Software registers
  logic [7:0] ctrl;
  logic [7:0] rate;
  logic [7:0] ofs_hi;
  logic [7:0] ofs_lo;
  logic [7:0] t1adj;
  logic [7:0] gate_a;
  logic [7:0] gate_b;
  logic [7:0] recov;
  logic [7:0] fine;
  logic [7:0] cal [4];

  // Write decode
  wire wr_ctrl   = bus.wr && (bus.addr == pmc_pkg::ADDR_CTRL);
  wire wr_rate   = bus.wr && (bus.addr == pmc_pkg::ADDR_RATE);
  wire wr_ofs_hi = bus.wr && (bus.addr == pmc_pkg::ADDR_OFS_HI);
  wire wr_ofs_lo = bus.wr && (bus.addr == pmc_pkg::ADDR_OFS_LO);
  wire wr_t1adj  = bus.wr && (bus.addr == pmc_pkg::ADDR_T1ADJ);
  wire wr_gate_a = bus.wr && (bus.addr == pmc_pkg::ADDR_GATE_A);
  wire wr_gate_b = bus.wr && (bus.addr == pmc_pkg::ADDR_GATE_B);
  wire wr_recov  = bus.wr && (bus.addr == pmc_pkg::ADDR_RECOV);
  wire wr_fine   = bus.wr && (bus.addr == pmc_pkg::ADDR_FINE);

  // Reserved bits are masked off on write so they read zero
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ctrl   <= pmc_pkg::RST_CTRL;
      rate   <= 8'h00;
      ofs_hi <= 8'h00;
      ofs_lo <= 8'h00;
      t1adj  <= 8'h00;
      gate_a <= 8'h00;
      gate_b <= 8'h00;
      recov  <= 8'h00;
      fine   <= 8'h00;
    end else begin
      if (wr_ctrl)   ctrl   <= bus.wdata & pmc_pkg::MASK_CTRL;
      if (wr_rate)   rate   <= bus.wdata & pmc_pkg::MASK_RATE;
      if (wr_ofs_hi) ofs_hi <= bus.wdata & pmc_pkg::MASK_OFS_HI;
      if (wr_ofs_lo) ofs_lo <= bus.wdata;
      if (wr_t1adj)  t1adj  <= bus.wdata & pmc_pkg::MASK_T1ADJ;
      if (wr_gate_a) gate_a <= bus.wdata & pmc_pkg::MASK_GATE_A;
      if (wr_gate_b) gate_b <= bus.wdata & pmc_pkg::MASK_GATE_B;
      if (wr_recov)  recov  <= bus.wdata & pmc_pkg::MASK_RECOV;
      if (wr_fine)   fine   <= bus.wdata;
    end
  end

  // Calibration bytes, most significant at the lowest address
  for (genvar g = 0; g < 4; g++) begin : g_cal
    wire wr_cal = bus.wr && (bus.addr == pmc_pkg::ADDR_CAL3 + 7'(g));
    always_ff @(posedge i_clk) begin
      if (i_reset) begin
        cal[g] <= 8'h00;
      end else if (wr_cal) begin
        cal[g] <= bus.wdata;
      end
    end
  end

  // Frame pulse edge; mode and reference pins are only trusted at this instant
  logic frame_d;
  wire  frame_rise = i_frame_pulse_8khz && !frame_d;
  logic [1:0] pin_mode;
  logic       pin_ref;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      frame_d  <= 1'b0;
      pin_mode <= pmc_pkg::MODE_FREE;
      pin_ref  <= 1'b0;
    end else begin
      frame_d <= i_frame_pulse_8khz;
      if (frame_rise) begin
        pin_mode <= {i_mode_sel_hi, i_mode_sel_lo};
        pin_ref  <= i_reference_choice;
      end
    end
  end

  // Pin or register source select
  wire       hw         = i_pin_control_select;
  wire [1:0] reg_mode   = {ctrl[pmc_pkg::CTRL_MODE_HI], ctrl[pmc_pkg::CTRL_MODE_LO]};
  wire [1:0] raw_mode   = hw ? pin_mode : reg_mode;
  // Reserved code 11 is held off as free-run to stay safe
  wire [1:0] eff_mode   = (raw_mode == 2'h3) ? pmc_pkg::MODE_FREE : raw_mode;
  wire       eff_narrow = hw ? i_filter_select : ctrl[pmc_pkg::CTRL_FILTER];
  wire       eff_ref    = hw ? pin_ref : ctrl[pmc_pkg::CTRL_REFERENCE_CHOICE];
  wire       eff_align  = hw ? i_phase_realign : ctrl[pmc_pkg::CTRL_ALIGN];

  // Status derived from the selected acquisition path
  wire sel_acq_hold = eff_ref ? i_secondary_acq_holdover_flag : i_primary_acq_holdover_flag;
  wire next_holdover = (eff_mode == pmc_pkg::MODE_HOLD) ||
                       ((eff_mode == pmc_pkg::MODE_NORMAL) && sel_acq_hold);
  wire next_lock = (eff_mode == pmc_pkg::MODE_NORMAL) && !sel_acq_hold && i_core_locked;

  // Realign edge detect and slew window
  logic       align_d;
  logic [15:0] phase_left;
  wire        align_fall = align_d && !eff_align;
  wire        slew_step;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      align_d    <= 1'b0;
      phase_left <= 16'h0000;
    end else begin
      align_d <= eff_align;
      if (align_fall) begin
        phase_left <= 16'(PHASE_NS);
      end else if (slew_step && phase_left != 16'h0000) begin
        phase_left <= phase_left - 16'h0001;
      end
    end
  end

  pmc_slew u_slew (
    .i_clk    (i_clk),
    .i_reset  (i_reset),
    .i_active (phase_left != 16'h0000),
    .i_narrow (eff_narrow),
    .o_step   (slew_step)
  );

  // Read mux; unlisted addresses answer zero
  wire [7:0] stat_byte = {2'h0, o_lock, o_holdover, 1'b0, i_core_freq_limit_flag, 2'h0};
  // Rate code sits in bits 4:3, bit 2 stays reserved
  wire [7:0] pri_byte  = {3'h0, i_primary_rate, 1'b0,
                          i_primary_acq_holdover_flag, i_primary_freq_limit_flag};
  wire [7:0] sec_byte  = {3'h0, i_secondary_rate, 1'b0,
                          i_secondary_acq_holdover_flag, i_secondary_freq_limit_flag};
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    case (bus.addr)
      pmc_pkg::ADDR_CTRL:   next_rdata = ctrl;
      pmc_pkg::ADDR_STAT:   next_rdata = stat_byte;
      pmc_pkg::ADDR_RATE:   next_rdata = rate;
      pmc_pkg::ADDR_OFS_HI: next_rdata = ofs_hi;
      pmc_pkg::ADDR_OFS_LO: next_rdata = ofs_lo;
      pmc_pkg::ADDR_IDENT:  next_rdata = IDENT_CODE;
      pmc_pkg::ADDR_T1ADJ:  next_rdata = t1adj;
      pmc_pkg::ADDR_GATE_A: next_rdata = gate_a;
      pmc_pkg::ADDR_GATE_B: next_rdata = gate_b;
      pmc_pkg::ADDR_RECOV:  next_rdata = recov;
      pmc_pkg::ADDR_FINE:   next_rdata = fine;
      pmc_pkg::ADDR_PRI_ST: next_rdata = pri_byte;
      pmc_pkg::ADDR_SEC_ST: next_rdata = sec_byte;
      pmc_pkg::ADDR_CAL3:   next_rdata = cal[0];
      pmc_pkg::ADDR_CAL2:   next_rdata = cal[1];
      pmc_pkg::ADDR_CAL1:   next_rdata = cal[2];
      pmc_pkg::ADDR_CAL0:   next_rdata = cal[3];
      default:              next_rdata = 8'h00;
    endcase
  end

  // Output registers; status pins run in both control modes
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_rdata                        <= 8'h00;
      o_lock                         <= 1'b0;
      o_holdover                     <= 1'b0;
      o_mode                         <= pmc_pkg::MODE_FREE;
      o_filter_narrow                <= 1'b0;
      o_reference_choice             <= 1'b0;
      o_realign_busy                 <= 1'b0;
      o_phase_step                   <= 1'b0;
      o_auto_recovery_disable        <= 1'b0;
      o_manual_recovery_request      <= 1'b0;
      o_coarse_phase_offset_value    <= 11'h000;
      o_phase_offset_enable          <= 1'b0;
      o_fine_phase_offset_value      <= 8'h00;
      o_t1_phase_offset_value        <= 3'h0;
      o_rate_select                  <= 2'h0;
      o_clock_disable                <= 14'h0000;
      o_oscillator_calibration_value <= 32'h0000_0000;
    end else begin
      if (bus.rd) o_rdata <= next_rdata;
      o_lock                         <= next_lock;
      o_holdover                     <= next_holdover;
      o_mode                         <= eff_mode;
      o_filter_narrow                <= eff_narrow;
      o_reference_choice             <= eff_ref;
      o_realign_busy                 <= (phase_left != 16'h0000);
      o_phase_step                   <= slew_step;
      o_auto_recovery_disable        <= recov[pmc_pkg::REC_DISABLE];
      o_manual_recovery_request      <= recov[pmc_pkg::REC_MANUAL];
      o_coarse_phase_offset_value    <= {ofs_hi[2:0], ofs_lo};
      o_phase_offset_enable          <= ofs_hi[3];
      o_fine_phase_offset_value      <= fine;
      o_t1_phase_offset_value        <= t1adj[5:3];
      o_rate_select                  <= rate[7:6];
      o_clock_disable                <= {gate_b[4:0], gate_a[5:1], 4'h0} >> 4;
      o_oscillator_calibration_value <= {cal[0], cal[1], cal[2], cal[3]};
    end
  end

  // Checks
  mode_sample_a: assert property (@(posedge i_clk) disable iff (i_reset)
    hw && !frame_rise && !$past(frame_rise) |-> $stable(pin_mode))
    else $error("Pin mode changed off frame edge");
  lock_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !(o_lock && o_holdover)) else $error("Lock and holdover together");
  hold_mode_a: assert property (@(posedge i_clk) disable iff (i_reset)
    eff_mode == pmc_pkg::MODE_HOLD |=> o_holdover)
    else $error("Holdover mode without holdover status");
  align_start_a: assert property (@(posedge i_clk) disable iff (i_reset)
    align_fall |=> ##1 o_realign_busy) else $error("Realign not started");
  sw_ignore_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !hw |=> o_filter_narrow == $past(ctrl[pmc_pkg::CTRL_FILTER]))
    else $error("Pin used in software control");
  reserved_zero_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (ctrl & ~pmc_pkg::MASK_CTRL) == 8'h00) else $error("Reserved bit set");
  ctrl_read_a: assert property (@(posedge i_clk) disable iff (i_reset)
    bus.rd && bus.addr == pmc_pkg::ADDR_CTRL && !bus.wr |=> o_rdata == $past(ctrl))
    else $error("Control readback wrong");
  cal_order_a: assert property (@(posedge i_clk) disable iff (i_reset)
    ##1 o_oscillator_calibration_value[31:24] == $past(cal[0]))
    else $error("Calibration byte order wrong");
  stat_read_a: assert property (@(posedge i_clk) disable iff (i_reset)
    bus.rd && bus.addr == pmc_pkg::ADDR_STAT |=> o_rdata[7:6] == 2'h0)
    else $error("Status reserved bits nonzero");
  realign_c: cover property (@(posedge i_clk) align_fall ##[1:20] o_realign_busy);
  hold_c:    cover property (@(posedge i_clk) o_holdover);
  lock_c:    cover property (@(posedge i_clk) o_lock);
  hwmode_c:  cover property (@(posedge i_clk) hw && frame_rise);
endmodule

/* verification/pmc_core_model.sv */
`timescale 1ns/10ps
// Behavioural PLL core beside the bank: frame pulse and loop status
module pmc_core_model #(
  parameter int         FRAME_CYC = 200,
  parameter logic [1:0] PRI_RATE  = 2'h1,
  parameter logic [1:0] SEC_RATE  = 2'h2
) (
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_ref_choice,
  input  wire logic [4:0] i_fault,
  output logic            o_frame_pulse,
  output logic            o_core_locked,
  output logic            o_pri_hold,
  output logic            o_sec_hold,
  output logic            o_pri_lim,
  output logic            o_sec_lim,
  output logic            o_core_lim,
  output logic [1:0]      o_pri_rate,
  output logic [1:0]      o_sec_rate
);
  int frame_cnt;

  // Short frame period keeps the run brief; one cycle high gives one rise
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      frame_cnt     <= 0;
      o_frame_pulse <= 1'b0;
    end else begin
      frame_cnt     <= (frame_cnt == FRAME_CYC - 1) ? 0 : frame_cnt + 1;
      o_frame_pulse <= (frame_cnt == FRAME_CYC - 1);
    end
  end

  // Fault order: core limit, sec limit, pri limit, sec holdover, pri holdover
  assign o_pri_hold    = i_fault[0];
  assign o_sec_hold    = i_fault[1];
  assign o_pri_lim     = i_fault[2];
  assign o_sec_lim     = i_fault[3];
  assign o_core_lim    = i_fault[4];
  assign o_pri_rate    = PRI_RATE;
  assign o_sec_rate    = SEC_RATE;
  // Core stays locked while the chosen acquisition loop is out of holdover
  assign o_core_locked = i_ref_choice ? !i_fault[1] : !i_fault[0];
endmodule

/* verification/testbench.sv */
`timescale 1ns/10ps
module testbench;
  localparam logic [7:0] IDENT = 8'h3c;  // Arbitrary identity value
  logic        i_clk, i_reset, pin_sel, ms_hi, ms_lo, filt_pin, ref_pin, align_pin;
  logic        frame, core_lock, pri_hold, sec_hold, pri_lim, sec_lim, core_lim;
  logic [1:0]  pri_rate, sec_rate, mode, rate_sel;
  logic [4:0]  fault;
  logic [6:0]  addr;
  logic [7:0]  wdata, rdata, fine;
  logic        wr, rd, lock, holdover, filt_narrow, ref_out, busy, step;
  logic        auto_dis, man_req, ofs_en;
  logic [10:0] coarse;
  logic [2:0]  t1;
  logic [13:0] clk_dis;
  logic [31:0] cal;
  int          num_errors, n_compared, cyc_no, k, steps, last, gap;
  logic [6:0]  ta [12] = '{7'h04, 7'h06, 7'h07, 7'h11, 7'h13, 7'h14,
                           7'h19, 7'h1a, 7'h40, 7'h41, 7'h42, 7'h43};
  logic [7:0]  tw [12] = '{8'hff, 8'hff, 8'ha5, 8'hff, 8'hff, 8'hff,
                           8'hff, 8'h5a, 8'h12, 8'h34, 8'h56, 8'h78};
  logic [7:0]  te [12] = '{8'hc0, 8'h0f, 8'ha5, 8'h38, 8'h3e, 8'h1f,
                           8'h03, 8'h5a, 8'h12, 8'h34, 8'h56, 8'h78};

  pmc_top #(.IDENT_CODE(IDENT), .PHASE_NS(3)) u_dut (
    .i_clk(i_clk), .i_reset(i_reset), .i_pin_control_select(pin_sel),
    .i_mode_sel_hi(ms_hi), .i_mode_sel_lo(ms_lo), .i_filter_select(filt_pin),
    .i_reference_choice(ref_pin), .i_phase_realign(align_pin),
    .i_frame_pulse_8khz(frame), .i_core_locked(core_lock),
    .i_core_freq_limit_flag(core_lim), .i_primary_acq_holdover_flag(pri_hold),
    .i_primary_freq_limit_flag(pri_lim), .i_primary_rate(pri_rate),
    .i_secondary_acq_holdover_flag(sec_hold), .i_secondary_freq_limit_flag(sec_lim),
    .i_secondary_rate(sec_rate), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .o_lock(lock), .o_holdover(holdover),
    .o_mode(mode), .o_filter_narrow(filt_narrow), .o_reference_choice(ref_out),
    .o_realign_busy(busy), .o_phase_step(step), .o_auto_recovery_disable(auto_dis),
    .o_manual_recovery_request(man_req), .o_coarse_phase_offset_value(coarse),
    .o_phase_offset_enable(ofs_en), .o_fine_phase_offset_value(fine),
    .o_t1_phase_offset_value(t1), .o_rate_select(rate_sel),
    .o_clock_disable(clk_dis), .o_oscillator_calibration_value(cal));

  pmc_core_model #(.FRAME_CYC(200)) u_core (
    .i_clk(i_clk), .i_reset(i_reset), .i_ref_choice(ref_out), .i_fault(fault),
    .o_frame_pulse(frame), .o_core_locked(core_lock), .o_pri_hold(pri_hold),
    .o_sec_hold(sec_hold), .o_pri_lim(pri_lim), .o_sec_lim(sec_lim),
    .o_core_lim(core_lim), .o_pri_rate(pri_rate), .o_sec_rate(sec_rate));

  // Free-running clock and cycle count for step spacing
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) cyc_no <= cyc_no + 1;

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // One-cycle strobe, launched just after an edge
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1;
    addr = a;
    wdata = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
  endtask

  // Read data is valid one cycle after the read edge
  task automatic chk_reg(input logic [6:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    #1;
    addr = a;
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    n_compared++;
    if (rdata !== exp) begin
      num_errors++;
      $display("ERROR t=%0t reg %h got %h exp %h", $time, a, rdata, exp);
    end
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    if (num_errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog well beyond the realign run of about ten thousand cycles
  initial begin
    repeat (50000) @(posedge i_clk);
    num_errors++;
    stop_test;
  end

  initial begin
    i_clk = 1'b0;
    i_reset = 1'b1;
    pin_sel = 1'b0;
    ms_hi = 1'b0;
    ms_lo = 1'b0;
    filt_pin = 1'b0;
    ref_pin = 1'b0;
    align_pin = 1'b0;
    fault = 5'h00;
    addr = 7'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    num_errors = 0;
    n_compared = 0;
    cyc(2);
    i_reset = 1'b0;
    chk_val(mode, 2'h2);
    chk_reg(7'h00, 8'h10);
    chk_reg(7'h0f, IDENT);
    // Reserved control bits are dropped; mode 11 never driven, bit 0 kept low
    wr_reg(7'h00, 8'hf6);
    chk_reg(7'h00, 8'h94);
    wr_reg(7'h00, 8'h84);
    cyc(1);
    chk_val({filt_narrow, ref_out}, 2'h3);
    for (k = 0; k < 3; k++) begin
      wr_reg(7'h00, {3'b000, k[1:0], 3'b000});
      cyc(1);
      chk_val(mode, k);
      chk_val(holdover, k == 1);
    end
    // Side registers; only defined addresses are touched
    for (k = 0; k < 12; k++) wr_reg(ta[k], tw[k]);
    for (k = 0; k < 12; k++) chk_reg(ta[k], te[k]);
    chk_val({ofs_en, coarse}, 12'hfa5);
    chk_val(cal, 32'h1234_5678);
    chk_val(clk_dis, 14'h03ff);
    chk_val({rate_sel, t1, fine}, 13'h1f5a);
    chk_val({auto_dis, man_req}, 2'h3);
    wr_reg(7'h13, 8'h04);
    wr_reg(7'h14, 8'h01);
    wr_reg(7'h19, 8'h02);
    cyc(1);
    chk_val(clk_dis, 14'h0022);
    chk_val({auto_dis, man_req}, 2'h1);
    // Status path in normal mode on the primary loop, then the secondary
    wr_reg(7'h00, 8'h00);
    cyc(2);
    chk_val({lock, holdover}, 2'h2);
    chk_reg(7'h01, 8'h20);
    fault = 5'h15;
    cyc(2);
    chk_val({lock, holdover}, 2'h1);
    chk_reg(7'h01, 8'h14);
    chk_reg(7'h20, 8'h0b);
    chk_reg(7'h28, 8'h10);
    wr_reg(7'h00, 8'h80);
    cyc(2);
    chk_val({lock, holdover}, 2'h2);
    fault = 5'h00;
    // Realign: bit 0 high then low, wide filter
    wr_reg(7'h00, 8'h01);
    wr_reg(7'h00, 8'h00);
    for (k = 0; k < 4 && busy !== 1'b1; k++) cyc(1);
    chk_val(busy, 1'b1);
    steps = 0;
    gap = 0;
    for (k = 0; k < 12000 && busy === 1'b1; k++) begin
      cyc(1);
      if (step === 1'b1) begin
        gap = cyc_no - last;
        last = cyc_no;
        steps++;
      end
    end
    chk_val(steps, 3);
    chk_val(gap, pmc_pkg::STEP_WIDE_CYC);
    // Pin control: mode and reference levels count only at a frame pulse rise
    pin_sel = 1'b1;
    @(posedge frame);
    cyc(3);
    chk_val(mode, 2'h0);
    ms_lo = 1'b1;
    ref_pin = 1'b1;
    filt_pin = 1'b1;
    wr_reg(7'h00, 8'h10);
    cyc(100);
    chk_val({mode, ref_out}, 3'h0);
    @(posedge frame);
    cyc(3);
    chk_val({mode, ref_out, filt_narrow, holdover}, 5'h0f);
    // Realign from the pin: high then low while pins rule
    align_pin = 1'b1;
    cyc(2);
    align_pin = 1'b0;
    cyc(3);
    chk_val(busy, 1'b1);
    // Back to registers: pins ignored, mode 10 and wide filter from the register
    pin_sel = 1'b0;
    cyc(3);
    chk_val({mode, filt_narrow}, 3'h4);
    stop_test;
  end
endmodule
